/* File: rtl/ued_pkg.sv */
// Package: shared types and constants for the endpoint receive DMA block
`default_nettype none
package ued_pkg;
	localparam int DATA_W = 32;
	localparam int SIZE_W = 16;
	localparam int PKT_W = 11;
	localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0000;
	localparam logic [2:0] BYTES_PER_WORD = 3'h4;
	localparam logic [1:0] BUF_DEPTH = 2'h2;

	typedef enum logic [1:0] {
		UED_IDLE = 2'b00,
		UED_MOVE = 2'b01,
		UED_DONE = 2'b11
	} ued_state_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [2:0] nbytes;
		logic last;
	} ued_word_t;

	typedef struct packed {
		logic whole_transfer_mode;
		logic per_packet_mode;
		logic iso;
		logic [SIZE_W-1:0] xfer_size;
	} ued_cfg_t;
endpackage : ued_pkg
`default_nettype wire

/* File: rtl/ued_buf2.sv */
// Two-entry valid/ready buffer in the receive data path
`default_nettype none
module ued_buf2 (
	input wire logic core_clk,
	input wire logic rstn,
	input wire ued_pkg::ued_word_t in_word,
	input wire logic in_valid,
	output logic in_ready,
	output ued_pkg::ued_word_t out_word,
	output logic out_valid,
	input wire logic out_ready
);
	typedef struct packed {
		ued_pkg::ued_word_t [1:0] mem;
		logic rd;
		logic wr;
		logic [1:0] cnt;
	} ued_buf_st_t;

	ued_buf_st_t st_r;
	ued_buf_st_t st_nxt;
	logic push;
	logic pop;

	assign in_ready = (st_r.cnt != ued_pkg::BUF_DEPTH);
	assign out_valid = (st_r.cnt != 2'h0);
	assign out_word = st_r.mem[st_r.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = in_word;
			st_nxt.wr = ~st_r.wr;
		end
		if (pop) begin
			st_nxt.rd = ~st_r.rd;
		end
		case ({push, pop})
			2'b10: st_nxt.cnt = st_r.cnt + 2'h1;
			2'b01: st_nxt.cnt = st_r.cnt - 2'h1;
			default: st_nxt.cnt = st_r.cnt;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	a_buf_no_overrun: assert property (@(posedge core_clk) disable iff (!rstn)
		st_r.cnt <= ued_pkg::BUF_DEPTH)
		else $error("buffer count above depth");
endmodule : ued_buf2
`default_nettype wire

/* File: rtl/ued_rx_dma.sv */
// Endpoint receive DMA: buffer to memory with per-transfer or per-packet interrupt
// Functional notes
// - A new transfer into an empty receive buffer is accepted and moved to memory.
// - A running transfer keeps the size latched at its start despite later rewrites.
// - Whole-transfer mode raises one interrupt only when the whole transfer ends.
// - Per-packet mode raises one interrupt for every packet.
// - Isochronous endpoints interrupt on every packet with no batching option.
`default_nettype none
module ued_rx_dma (
	input wire logic core_clk,
	input wire logic rstn,
	input wire ued_pkg::ued_cfg_t cfg,
	input wire ued_pkg::ued_word_t rx_word,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [ued_pkg::PKT_W-1:0] max_pkt,
	output ued_pkg::ued_word_t mem_word,
	output logic mem_valid,
	input wire logic mem_ready,
	output logic xfer_irq,
	output logic busy,
	output logic [ued_pkg::SIZE_W-1:0] byte_count
);
	typedef struct packed {
		ued_pkg::ued_state_t state;
		logic [ued_pkg::SIZE_W-1:0] size;
		logic [ued_pkg::SIZE_W-1:0] count;
		logic [ued_pkg::PKT_W-1:0] pkt_cnt;
		logic batch;
		logic irq;
		ued_pkg::ued_word_t out;
		logic out_v;
	} ued_st_t;

	ued_st_t st_r;
	ued_st_t st_nxt;
	ued_pkg::ued_word_t b_word;
	logic b_valid;
	logic b_ready;
	logic take;
	logic [ued_pkg::SIZE_W-1:0] cnt_add;
	logic [ued_pkg::PKT_W-1:0] pkt_add;
	logic short_pkt;
	logic pkt_end;

	// Stalls toward the source come from this buffer, so no word is lost
	ued_buf2 u_buf (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_word(rx_word),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.out_word(b_word),
		.out_valid(b_valid),
		.out_ready(b_ready)
	);

	// Output stage takes a word when empty or draining, except in the done cycle
	assign b_ready = (st_r.state != ued_pkg::UED_DONE) && (!st_r.out_v || mem_ready);
	assign take = b_valid && b_ready;
	assign cnt_add = st_r.count + {{(ued_pkg::SIZE_W-3){1'b0}}, b_word.nbytes};
	assign pkt_add = st_r.pkt_cnt + {{(ued_pkg::PKT_W-3){1'b0}}, b_word.nbytes};
	assign pkt_end = b_word.last;
	// A packet below max size ends the transfer early
	assign short_pkt = pkt_end && (pkt_add < max_pkt);

	assign mem_word = st_r.out;
	assign mem_valid = st_r.out_v;
	assign xfer_irq = st_r.irq;
	assign busy = (st_r.state != ued_pkg::UED_IDLE);
	assign byte_count = st_r.count;

	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		if (st_r.out_v && mem_ready) begin
			st_nxt.out_v = 1'b0;
		end
		if (take) begin
			st_nxt.out = b_word;
			st_nxt.out_v = 1'b1;
			st_nxt.pkt_cnt = pkt_end ? '0 : pkt_add;
		end
		case (st_r.state)
			ued_pkg::UED_IDLE: begin
				if (take) begin
					// Size and mode are latched here and held for the whole transfer
					st_nxt.size = cfg.xfer_size;
					st_nxt.batch = cfg.whole_transfer_mode && !cfg.iso;
					st_nxt.count = cnt_add;
					st_nxt.state = ued_pkg::UED_MOVE;
					if (!(cfg.whole_transfer_mode && !cfg.iso)) begin
						// Per-packet and isochronous: one interrupt per packet
						st_nxt.irq = pkt_end;
						if (pkt_end) begin
							st_nxt.state = ued_pkg::UED_DONE;
						end
					end else if (cnt_add >= cfg.xfer_size || short_pkt) begin
						st_nxt.state = ued_pkg::UED_DONE;
						st_nxt.irq = 1'b1;
					end
				end
			end
			ued_pkg::UED_MOVE: begin
				if (take) begin
					st_nxt.count = cnt_add;
					if (!st_r.batch) begin
						st_nxt.irq = pkt_end;
						if (pkt_end) begin
							st_nxt.state = ued_pkg::UED_DONE;
						end
					end else if (cnt_add >= st_r.size || short_pkt) begin
						st_nxt.state = ued_pkg::UED_DONE;
						st_nxt.irq = 1'b1;
					end
				end
			end
			ued_pkg::UED_DONE: begin
				// One cycle gap lets software reload the size before the next transfer
				st_nxt.state = ued_pkg::UED_IDLE;
				st_nxt.count = '0;
				st_nxt.pkt_cnt = '0;
			end
			default: st_nxt.state = ued_pkg::UED_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st_r <= '{state: ued_pkg::UED_IDLE, size: ued_pkg::SIZE_RST, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	sequence s_batch_word;
		take && st_r.batch && st_r.state == ued_pkg::UED_MOVE;
	endsequence

	// A transfer opens on the first word taken while idle
	sequence s_xfer_start;
		take && st_r.state == ued_pkg::UED_IDLE;
	endsequence

	// Completion is a single interrupt cycle, so software never sees a level
	sequence s_irq_pulse;
		xfer_irq ##1 !xfer_irq;
	endsequence

	a_size_latch: assert property (@(posedge core_clk) disable iff (!rstn)
		s_xfer_start |=> st_r.size == $past(cfg.xfer_size))
		else $error("size not latched at transfer start");

	a_size_held: assert property (@(posedge core_clk) disable iff (!rstn)
		st_r.state == ued_pkg::UED_MOVE && $past(st_r.state) == ued_pkg::UED_MOVE
		|-> st_r.size == $past(st_r.size))
		else $error("latched size changed mid transfer");

	a_mode_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		busy && $past(busy) |-> st_r.batch == $past(st_r.batch))
		else $error("transfer mode changed mid transfer");

	a_accept_idle: assert property (@(posedge core_clk) disable iff (!rstn)
		st_r.state == ued_pkg::UED_IDLE && b_valid && (!mem_valid || mem_ready)
		|=> busy)
		else $error("idle endpoint did not start");

	a_latch_mode: assert property (@(posedge core_clk) disable iff (!rstn)
		s_xfer_start |=> st_r.batch == ($past(cfg.whole_transfer_mode) && !$past(cfg.iso)))
		else $error("transfer mode not latched");

	a_iso_unbatched: assert property (@(posedge core_clk) disable iff (!rstn)
		busy && cfg.iso |-> !st_r.batch)
		else $error("isochronous endpoint batched");

	a_batch_one_irq: assert property (@(posedge core_clk) disable iff (!rstn)
		s_batch_word ##0 (cnt_add < st_r.size && !short_pkt) |=> !xfer_irq)
		else $error("whole transfer interrupt too early");

	a_batch_done_irq: assert property (@(posedge core_clk) disable iff (!rstn)
		s_batch_word ##0 (cnt_add >= st_r.size) |=> s_irq_pulse)
		else $error("whole transfer end missed");

	a_short_end: assert property (@(posedge core_clk) disable iff (!rstn)
		take && short_pkt |=> s_irq_pulse)
		else $error("short packet did not end transfer");

	a_pkt_irq: assert property (@(posedge core_clk) disable iff (!rstn)
		take && pkt_end && !st_r.batch && st_r.state == ued_pkg::UED_MOVE
		|=> xfer_irq)
		else $error("packet interrupt missing");

	a_iso_per_pkt: assert property (@(posedge core_clk) disable iff (!rstn)
		take && pkt_end && cfg.iso |=> xfer_irq)
		else $error("iso packet interrupt missing");

	a_irq_cause: assert property (@(posedge core_clk) disable iff (!rstn)
		xfer_irq |-> $past(take))
		else $error("interrupt without a completing word");

	a_irq_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
		xfer_irq |-> st_r.state == ued_pkg::UED_DONE ##1 st_r.state == ued_pkg::UED_IDLE)
		else $error("interrupt without completion");

	a_pkt_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		take && pkt_end |=> st_r.pkt_cnt == '0)
		else $error("packet byte count not cleared");

	a_count_step: assert property (@(posedge core_clk) disable iff (!rstn)
		take |=> byte_count == $past(byte_count) + 16'($past(b_word.nbytes)))
		else $error("byte count did not follow word");

	a_count_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		st_r.state == ued_pkg::UED_DONE |=> byte_count == '0)
		else $error("byte count kept after completion");

	a_done_pause: assert property (@(posedge core_clk) disable iff (!rstn)
		st_r.state == ued_pkg::UED_DONE |-> !take)
		else $error("word taken in completion cycle");

	a_mem_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		mem_valid && !mem_ready |=> mem_valid && $stable(mem_word))
		else $error("memory word dropped under stall");
endmodule : ued_rx_dma
`default_nettype wire

/* File: verification/ued_host_model.sv */
// Host model that sends one packet of words per go pulse
`default_nettype none
module ued_host_model (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic go,
	input wire logic [3:0] n_words,
	input wire logic [2:0] tail,
	output ued_pkg::ued_word_t rx_word,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic idle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_r;
	assign idle = (left_r == 4'h0);
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			left_r <= 4'h0;
			rx_valid <= 1'b0;
			rx_word <= '0;
		end else if (go && idle) begin
			left_r <= n_words;
			rx_valid <= 1'b1;
			rx_word.data <= 32'h0000_0001;
			rx_word.nbytes <= (n_words == 4'h1) ? tail : 3'h4;
			rx_word.last <= (n_words == 4'h1);
		end else if (rx_valid && rx_ready) begin
			if (left_r == 4'h1) begin
				// Released data is inverted so a stale word never looks valid
				left_r <= 4'h0;
				rx_valid <= 1'b0;
				rx_word <= ~rx_word;
			end else begin
				left_r <= left_r - 4'h1;
				rx_word.data <= rx_word.data + 32'h1;
				rx_word.nbytes <= (left_r == 4'h2) ? tail : 3'h4;
				rx_word.last <= (left_r == 4'h2);
			end
		end
	end
endmodule : ued_host_model
`default_nettype wire

/* File: verification/test_ued_rx_dma.sv */
// Testbench for the endpoint receive DMA block
`default_nettype none
module test_ued_rx_dma;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic go = 1'b0;
	logic [3:0] n_words = 4'h0;
	logic [2:0] tail = 3'h4;
	logic mem_ready = 1'b0;
	logic [ued_pkg::PKT_W-1:0] max_pkt = 11'h008;
	ued_pkg::ued_cfg_t cfg = '0;
	ued_pkg::ued_word_t rx_word;
	ued_pkg::ued_word_t mem_word;
	logic rx_valid, rx_ready, mem_valid, xfer_irq, busy, host_idle;
	logic [ued_pkg::SIZE_W-1:0] byte_count;
	int n_mismatch = 0;
	int tests_run = 0;
	int irq_cnt = 0;
	int byte_cnt = 0;
	logic [3:0] word_idx = 4'h1;
	always #5 core_clk = ~core_clk;
	// Memory side stalls every other cycle so the buffer fills
	always @(posedge core_clk) begin
		mem_ready <= ~mem_ready;
		if (xfer_irq === 1'b1) begin
			irq_cnt++;
		end
		if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
			byte_cnt += mem_word.nbytes;
			// Words leave in the order sent, with the packet end on the last one
			check(mem_word.data[15:0], 16'(word_idx), "word order");
			check(16'(mem_word.last), 16'(word_idx == n_words), "packet end");
			word_idx <= (word_idx == n_words) ? 4'h1 : word_idx + 4'h1;
		end
	end
	ued_host_model u_host (.core_clk(core_clk), .rstn(rstn), .go(go), .n_words(n_words),
		.tail(tail), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.idle(host_idle));
	ued_rx_dma u_dut (.core_clk(core_clk), .rstn(rstn), .cfg(cfg), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .max_pkt(max_pkt), .mem_word(mem_word),
		.mem_valid(mem_valid), .mem_ready(mem_ready), .xfer_irq(xfer_irq), .busy(busy),
		.byte_count(byte_count));
	task automatic end_sim();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask : check
	task automatic send(input logic [3:0] n, input logic [2:0] t);
		int i;
		@(posedge core_clk);
		go <= 1'b1;
		n_words <= n;
		tail <= t;
		@(posedge core_clk);
		go <= 1'b0;
		#1;
		for (i = 0; i < 100 && host_idle !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		check(16'(i < 100), 16'h1, "host stalled");
		if (i >= 100) begin
			end_sim();
		end
	endtask : send
	task automatic settle(input int exp_irq, input int exp_bytes);
		int i;
		for (i = 0; i < 200 && irq_cnt < exp_irq; i++) begin
			@(posedge core_clk);
		end
		check(16'(i < 200), 16'h1, "irq wait");
		if (i >= 200) begin
			end_sim();
		end
		// Idle gap also lets the next transfer latch fresh settings
		repeat (8) @(posedge core_clk);
		#1;
		check(16'(irq_cnt), 16'(exp_irq), "irq count");
		check(16'(byte_cnt), 16'(exp_bytes), "bytes");
		irq_cnt = 0;
		byte_cnt = 0;
	endtask : settle
	task automatic t_whole();
		@(posedge core_clk);
		cfg <= '{1'b1, 1'b0, 1'b0, 16'h0010};
		send(4'h2, 3'h4);
		settle(0, 8);
		check(byte_count, 16'h0008, "running count");
		check(16'(busy), 16'h0001, "busy mid transfer");
		send(4'h2, 3'h4);
		settle(1, 8);
		check(byte_count, 16'h0000, "count after end");
		check(16'(busy), 16'h0000, "busy after end");
	endtask : t_whole
	task automatic t_short();
		@(posedge core_clk);
		cfg <= '{1'b1, 1'b0, 1'b0, 16'h0040};
		send(4'h1, 3'h3);
		settle(1, 3);
	endtask : t_short
	task automatic t_pkt();
		@(posedge core_clk);
		cfg <= '{1'b0, 1'b1, 1'b0, 16'h0040};
		send(4'h2, 3'h4);
		send(4'h2, 3'h4);
		send(4'h2, 3'h4);
		settle(3, 24);
	endtask : t_pkt
	task automatic t_iso();
		@(posedge core_clk);
		cfg <= '{1'b1, 1'b0, 1'b1, 16'h0040};
		send(4'h2, 3'h4);
		send(4'h2, 3'h4);
		settle(2, 16);
		send(4'h1, 3'h4);
		settle(1, 4);
	endtask : t_iso
	task automatic t_reset();
		@(posedge core_clk);
		cfg <= '{1'b1, 1'b0, 1'b0, 16'h0010};
		send(4'h2, 3'h4);
		settle(0, 8);
		// A reset that cuts a transfer must drop its count
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		check(16'({rx_ready, mem_valid, xfer_irq, busy}), 16'h8, "outputs after reset");
		check(byte_count, 16'h0000, "count after reset");
		send(4'h2, 3'h4);
		settle(0, 8);
		check(byte_count, 16'h0008, "fresh count");
	endtask : t_reset
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		check(16'({rx_ready, mem_valid, xfer_irq, busy}), 16'h8, "reset outputs");
		check(byte_count, 16'h0, "reset count");
		t_whole();
		t_short();
		t_pkt();
		t_iso();
		t_reset();
		end_sim();
	end
endmodule : test_ued_rx_dma
`default_nettype wire
